/* File: adcsl_pkg.sv */
// adcsl_pkg: shared constants of the two-wire converter control link
// assumes: 20 MHz core clock on both ends
package adcsl_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CONV_CLK_HZ = 1_560_000;
    localparam int CONV_TIME_NS = 7700;
    localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int SCL_HALF_CYCLES = 4;
    localparam logic [3:0] ADDR_FIXED = 4'h5;
    localparam int CTRL_VALID_BIT = 7;
    localparam int CHAN_MSB = 6;
    localparam int CHAN_LSB = 4;
    localparam int RANGE_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int PD_HIGH_BIT = 1;
    localparam int PD_LOW_BIT = 0;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_STANDBY = 2'h2;
    localparam logic [1:0] PD_DEEP = 2'h3;
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_CMD = 32'h0000_0004;
    localparam logic [31:0] REG_STATUS = 32'h0000_0008;
    localparam logic [31:0] REG_RESULT = 32'h0000_000C;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_READ_BIT = 1;
endpackage

/* File: adcsl_if.sv */
// adcsl_if: the two-wire bus between master and converter slave
// assumes: this interface resolves the open-drain wires from the enables
`timescale 1ns/10ps
interface adcsl_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o) ? 1'b0 : 1'b1;
    modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
        output sda_m_o, output sda_m_oe);
endinterface

/* File: adcsl_slave.sv */
// adcsl_slave: two-wire slave of an eight-channel 12-bit converter
// assumes: bus pins asynchronous to CORE_CLK_I; analog core outside
`timescale 1ns/10ps
module adcsl_slave
    import adcsl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // two-wire bus
    adcsl_if.slave BUS,
    // address straps
    input wire logic [2:0] ADDRESS_SELECT_PINS_I,
    // analog core
    output logic [2:0] CHANNEL_CODE_O,
    output logic FULL_SCALE_CHOICE_O,
    output logic POLARITY_CHOICE_O,
    output logic STANDBY_SLEEP_O,
    output logic DEEP_SLEEP_O,
    output logic ACQUIRE_O,
    output logic CONVERT_START_O,
    output logic CONVERTING_O,
    input wire logic CONVERT_DONE_I,
    input wire logic [11:0] CONVERT_RESULT_I
);
    import adcsl_pkg::*;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CTRL, ST_CTRL_ACK, ST_TX, ST_TX_ACK,
        ST_IGNORE
    } adcsl_state_e;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    adcsl_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic read_dir;
    logic byte_idx;
    logic [7:0] ctrl;
    logic [15:0] result;
    logic ctrl_pend;
    logic sda_drive;
    logic [1:0] pd_mode;
    logic conv_end;
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;

    // two-stage synchronisers
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            pins_s1 <= 3'h0;
            pins_s2 <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[0], BUS.scl};
            pins_s1 <= ADDRESS_SELECT_PINS_I;
            pins_s2 <= pins_s1;
            sda_sync <= {sda_sync[0], BUS.sda};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_rise = scl_sync[1] & ~scl_d;
    assign scl_fall = ~scl_sync[1] & scl_d;
    assign start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign stop_det = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
    assign conv_end = CONVERTING_O & CONVERT_DONE_I;

    // bit engine: samples on rising scl, shifts out on falling scl
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            read_dir <= 1'b0;
            byte_idx <= 1'b0;
            sda_drive <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_drive <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_drive <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_CTRL: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_sync[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (shift[7:1] == {ADDR_FIXED,
                                pins_s2}) begin
                                read_dir <= shift[0];
                                sda_drive <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end else if (shift[CTRL_VALID_BIT]) begin
                            sda_drive <= 1'b1;
                            state <= ST_CTRL_ACK;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_CTRL_ACK: begin
                    if (scl_fall) begin
                        if (state == ST_ADDR_ACK && read_dir) begin
                            state <= ST_TX;
                            byte_idx <= 1'b0;
                            shift <= result[15:8];
                            sda_drive <= ~result[15];
                            bit_cnt <= 4'h1;
                        end else begin
                            sda_drive <= 1'b0;
                            state <= (state == ST_ADDR_ACK) ? ST_CTRL
                                : ST_IGNORE;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            sda_drive <= 1'b0;
                            state <= ST_TX_ACK;
                        end else begin
                            sda_drive <= ~shift[7 - 32'(bit_cnt)];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // acknowledge value is not examined
                    if (scl_fall) begin
                        // both bytes sent: release so the master can stop
                        byte_idx <= 1'b1;
                        shift <= result[7:0];
                        sda_drive <= byte_idx ? 1'b0 : ~result[7];
                        bit_cnt <= 4'h1;
                        state <= byte_idx ? ST_IGNORE : ST_TX;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign BUS.sda_s_o = 1'b0;
    assign BUS.sda_s_oe = sda_drive;

    // control byte, acquisition and conversion
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl <= 8'h00;
            ctrl_pend <= 1'b0;
            ACQUIRE_O <= 1'b0;
            CONVERT_START_O <= 1'b0;
            CONVERTING_O <= 1'b0;
        end else begin
            CONVERT_START_O <= 1'b0;
            // acquisition starts on the sixth scl rise of the control byte when bit 7 is set
            if (state == ST_CTRL && scl_rise && bit_cnt == 4'h5
                && shift[4]) begin
                ACQUIRE_O <= 1'b1;
            end
            if (state == ST_CTRL && scl_fall && bit_cnt == 4'h8
                && shift[CTRL_VALID_BIT]) begin
                ctrl <= shift;
                ctrl_pend <= 1'b1;
            end
            // a new start wins over the end of the previous conversion
            if (conv_end) begin
                CONVERTING_O <= 1'b0;
            end
            if (stop_det && ACQUIRE_O && ctrl_pend) begin
                ACQUIRE_O <= 1'b0;
                CONVERT_START_O <= 1'b1;
                CONVERTING_O <= 1'b1;
                ctrl_pend <= 1'b0;
            end else if (start_det) begin
                ACQUIRE_O <= 1'b0;
                ctrl_pend <= 1'b0;
            end
        end
    end

    // result register, coded as the analog core delivers it
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            result <= 16'h0000;
        end else if (conv_end) begin
            result <= {CONVERT_RESULT_I, 4'h0};
        end
    end

    // power-down takes effect after conversion, cleared on a write address
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pd_mode <= PD_NORMAL;
        end else if (state == ST_ADDR_ACK && !read_dir && scl_rise) begin
            pd_mode <= PD_NORMAL;
        end else if (conv_end) begin
            pd_mode <= {ctrl[PD_HIGH_BIT], ctrl[PD_LOW_BIT]};
        end
    end

    assign CHANNEL_CODE_O = ctrl[CHAN_MSB:CHAN_LSB];
    assign FULL_SCALE_CHOICE_O = ctrl[RANGE_BIT];
    assign POLARITY_CHOICE_O = ctrl[POL_BIT];
    assign STANDBY_SLEEP_O = (pd_mode == PD_STANDBY);
    assign DEEP_SLEEP_O = (pd_mode == PD_DEEP);

    // the analog core ends a conversion after CONV_LEN cycles
    logic unused_len;
    assign unused_len = (CONV_LEN == 0);
endmodule

/* File: adcsl_master.sv */
// adcsl_master: two-wire master with AHB-Lite register access
// assumes: single-word AHB-Lite transfers, OKAY response only
`timescale 1ns/10ps
module adcsl_master
    import adcsl_pkg::*;
#(
    parameter int HALF = SCL_HALF_CYCLES
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // two-wire bus
    adcsl_if.master BUS
);
    import adcsl_pkg::*;

    typedef enum {
        M_IDLE, M_START, M_BIT, M_STOP
    } adcsl_mstate_e;

    adcsl_mstate_e state;
    logic [7:0] ctrl_byte;
    logic [2:0] addr_low;
    logic [15:0] rd_data;
    logic busy;
    logic is_read;
    logic [5:0] bit_no;
    logic [5:0] last_bit;
    logic [7:0] div;
    logic [1:0] phase;
    logic tick;
    logic scl_low;
    logic sda_low;
    logic [1:0] sda_sync;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [3:0] go_req;
    logic [26:0] frame;

    // ahb-lite: one-cycle answers, no wait states
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
            HRDATA_O <= 32'h0000_0000;
        end else begin
            wr_pend <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
            if (HSEL_I & HREADY_I & HTRANS_I[1]) begin
                wr_addr <= HADDR_I;
                if (HADDR_I == REG_CTRL) begin
                    HRDATA_O <= {21'h0, addr_low, ctrl_byte};
                end else if (HADDR_I == REG_STATUS) begin
                    HRDATA_O <= {31'h0, busy};
                end else if (HADDR_I == REG_RESULT) begin
                    HRDATA_O <= {16'h0, rd_data};
                end else begin
                    HRDATA_O <= 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_byte <= 8'h80;
            addr_low <= 3'h0;
        end else if (wr_pend && wr_addr == REG_CTRL) begin
            ctrl_byte <= HWDATA_I[7:0];
            addr_low <= HWDATA_I[10:8];
        end
    end
    assign go_req = {2'h0, wr_pend && wr_addr == REG_CMD
        && HWDATA_I[CMD_GO_BIT], HWDATA_I[CMD_READ_BIT]};

    // quarter-bit tick from the core clock
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div <= 8'h00;
        end else if (div == 8'(HALF - 1)) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end
    assign tick = (div == 8'(HALF - 1));

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sda_sync <= 2'h3;
        end else begin
            sda_sync <= {sda_sync[0], BUS.sda};
        end
    end

    // frame: address, then the control byte or two read bytes; first read byte acked, other ack slots released
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= M_IDLE;
            busy <= 1'b0;
            is_read <= 1'b0;
            bit_no <= 6'h00;
            last_bit <= 6'h00;
            phase <= 2'h0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            frame <= 27'h0;
            rd_data <= 16'h0000;
        end else begin
            case (state)
                M_IDLE: begin
                    if (go_req[1]) begin
                        busy <= 1'b1;
                        is_read <= go_req[0];
                        frame <= {ADDR_FIXED, addr_low, go_req[0], 1'b1,
                            go_req[0] ? 9'h1FF : {ctrl_byte, 1'b1},
                            9'h1FF};
                        last_bit <= go_req[0] ? 6'd27 : 6'd18;
                        state <= M_START;
                        phase <= 2'h0;
                    end
                end
                M_START: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_low <= 1'b1;
                        end else if (phase == 2'h1) begin
                            scl_low <= 1'b1;
                            bit_no <= 6'h00;
                            phase <= 2'h0;
                            state <= M_BIT;
                        end
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_low <= ~frame[26];
                            if (is_read && bit_no >= 6'd9) begin
                                // ack first byte, nack second
                                sda_low <= (bit_no == 6'd17);
                            end
                        end else if (phase == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (phase == 2'h2) begin
                            if (is_read && bit_no >= 6'd9 && bit_no != 6'd17
                                && bit_no != 6'd26) begin
                                rd_data <= {rd_data[14:0], sda_sync[1]};
                            end
                        end else begin
                            scl_low <= 1'b1;
                            frame <= {frame[25:0], 1'b1};
                            bit_no <= bit_no + 6'h01;
                            if (bit_no + 6'h01 == last_bit) begin
                                state <= M_STOP;
                                phase <= 2'h0;
                            end
                        end
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_low <= 1'b1;
                        end else if (phase == 2'h1) begin
                            scl_low <= 1'b0;
                        end else if (phase == 2'h2) begin
                            sda_low <= 1'b0;
                            busy <= 1'b0;
                            state <= M_IDLE;
                        end
                    end
                end
                default: state <= M_IDLE;
            endcase
        end
    end

    assign BUS.scl_o = 1'b0;
    assign BUS.scl_oe = scl_low;
    assign BUS.sda_m_o = 1'b0;
    assign BUS.sda_m_oe = sda_low;
endmodule

/* File: adcsl_checker.sv */
// adcsl_checker: wire-level checks of the two-wire link
// assumes: both ends run on CORE_CLK_I, bus lines pulled up
`timescale 1ns/10ps
module adcsl_checker (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // bus signals
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe
);
    logic scl_q, sda_q, rw, ack, rise, start;
    logic [5:0] cnt;
    logic [4:0] hi;
    assign rise = scl & ~scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // scl rises since the last start, direction and address ack
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cnt <= 6'h0;
            rw <= 1'b0;
            ack <= 1'b0;
        end else if (start) begin
            cnt <= 6'h0;
        end else if (rise) begin
            cnt <= (cnt == 6'h3F) ? cnt : cnt + 6'h1;
            rw <= (cnt == 6'h7) ? sda : rw;
            ack <= (cnt == 6'h8) ? ~sda : ack;
        end
    end
    // cycles since scl last went high, held at zero while scl is low, saturating
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hi <= 5'h0;
        end else if (!scl) begin
            hi <= 5'h0;
        end else if (hi != 5'h1F) begin
            hi <= hi + 5'h1;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    slave_open_drain_a: assert property (sda_s_oe |-> !sda_s_o)
        else $error("slave drives sda high");
    master_open_drain_a: assert property (scl_oe |-> !scl_o)
        else $error("master drives scl high");
    slave_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave changed sda while scl high");
    slave_hold_a: assert property ($rose(sda_s_oe) |-> sda_s_oe[*8])
        else $error("slave pull too short");
    scl_high_a: assert property ($rose(scl) |-> scl[*6])
        else $error("scl high phase too short");
    stop_free_a: assert property (hi == 5'd15 |-> !sda_s_oe)
        else $error("slave holds sda while scl idles high");
    addr_quiet_a: assert property (rise && cnt < 6'h8 |-> !sda_s_oe)
        else $error("slave drives during address");
    ctrl_quiet_a: assert property (rise && !rw && cnt inside {[9:16]}
        |-> !sda_s_oe) else $error("slave drives during control");
    ack_release_a: assert property (rise && rw
        && (cnt == 6'd17 || cnt == 6'd26) |-> !sda_s_oe)
        else $error("slave holds sda in master ack slot");
    zero_pad_a: assert property (rise && rw && ack
        && cnt inside {[22:25]} |-> !sda) else $error("pad bit not zero");
endmodule

/* File: testbench.sv */
// testbench: drives the master over AHB-Lite, models the analog core
// assumes: one master, one slave on a shared interface
`timescale 1ns/10ps
module testbench;
    import adcsl_pkg::*;
    localparam int LIMIT = 2000;
    logic clk, rstn, hwrite, hready, hresp;
    logic done = 1'b0;
    logic full_scale_choice, pol, stby, deep, acq, cstart, conv;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] pins, chan;
    logic [11:0] res;
    int mismatches, check_count, starts, acq_cyc, ccnt;
    adcsl_if bus ();
    adcsl_master i_adcsl_master (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .BUS(bus));
    adcsl_slave i_adcsl_slave (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .BUS(bus), .ADDRESS_SELECT_PINS_I(pins), .CHANNEL_CODE_O(chan),
        .FULL_SCALE_CHOICE_O(full_scale_choice), .POLARITY_CHOICE_O(pol),
        .STANDBY_SLEEP_O(stby), .DEEP_SLEEP_O(deep), .ACQUIRE_O(acq),
        .CONVERT_START_O(cstart), .CONVERTING_O(conv),
        .CONVERT_DONE_I(done), .CONVERT_RESULT_I(res));
    adcsl_checker i_adcsl_checker (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .scl(bus.scl), .sda(bus.sda), .scl_o(bus.scl_o),
        .scl_oe(bus.scl_oe), .sda_s_o(bus.sda_s_o),
        .sda_s_oe(bus.sda_s_oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // analog core: done pulse a fixed time after each start
    always @(posedge clk) begin
        done <= !cstart && ccnt == 1;
        ccnt <= cstart ? CONV_CYCLES : (ccnt > 0 ? ccnt - 1 : 0);
        starts <= starts + (cstart === 1'b1);
        acq_cyc <= acq_cyc + (acq === 1'b1);
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic ahb(logic wr, logic [31:0] a, logic [31:0] d,
        output logic [31:0] q);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic xfer(logic [1:0] cmd);
        logic [31:0] q;
        int n;
        ahb(1'b1, REG_CMD, {30'h0, cmd}, q);
        n = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && n < LIMIT) begin
            ahb(1'b0, REG_STATUS, 32'h0, q);
            n++;
        end
        check("frame done", 32'h0, {31'h0, q[0]});
        repeat (4) @(posedge clk);
    endtask
    task automatic wr_ctrl(logic [2:0] tgt, logic [7:0] c);
        logic [31:0] q;
        ahb(1'b1, REG_CTRL, {21'h0, tgt, c}, q);
        xfer(2'h1);
    endtask
    task automatic wait_conv();
        int n;
        n = 0;
        while (conv !== 1'b0 && n < LIMIT) begin
            @(posedge clk);
            n++;
        end
        check("conv done", 32'h0, {31'h0, conv});
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        ahb(1'b0, REG_CTRL, 32'h0, q);
        check("ctrl reset", 32'h80, {24'h0, q[7:0]});
        check("okay", 32'h0, {31'h0, hresp});
        ahb(1'b0, REG_RESULT, 32'h0, q);
        check("result reset", 32'h0, q);
        check("outputs reset", 32'h0, {chan, stby, deep, acq});
        ahb(1'b1, 32'h10, 32'hFF, q);
        ahb(1'b0, 32'h10, 32'h0, q);
        check("unmapped", 32'h0, q);
    endtask
    task automatic t_decode();
        logic [2:0] c;
        logic [1:0] pd;
        int s, a;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            pd = {c[2], c[0]};
            s = starts;
            a = acq_cyc;
            wr_ctrl(3'h5, {1'b1, c, c[0], c[1], pd});
            check("channel", {29'h0, c}, {29'h0, chan});
            check("range", {31'h0, c[0]}, {31'h0, full_scale_choice});
            check("polarity", {31'h0, c[1]}, {31'h0, pol});
            check("starts", s + 1, starts);
            check("acquired", 32'h1, {31'h0, acq_cyc > a});
            check("awake", 32'h0, {30'h0, stby, deep});
            wait_conv();
            check("standby", {31'h0, pd == PD_STANDBY}, {31'h0, stby});
            check("deep", {31'h0, pd == PD_DEEP}, {31'h0, deep});
        end
    endtask
    task automatic t_read();
        logic [31:0] q;
        res = 12'hA5C;
        wr_ctrl(3'h5, 8'h80);
        wait_conv();
        wr_ctrl(3'h5, 8'h80);
        check("converting", 32'h1, {31'h0, conv});
        xfer(2'h3);
        ahb(1'b0, REG_RESULT, 32'h0, q);
        check("result", 32'hA5C0, {16'h0, q[15:0]});
        wait_conv();
        res = 12'h3C7;
        wr_ctrl(3'h5, 8'h80);
        wait_conv();
        xfer(2'h3);
        ahb(1'b0, REG_RESULT, 32'h0, q);
        check("result low msb", 32'h3C70, {16'h0, q[15:0]});
    endtask
    task automatic t_refuse();
        int s;
        s = starts;
        wr_ctrl(3'h2, 8'hF0);
        check("no match", s, starts);
        check("chan kept", 32'h0, {29'h0, chan});
        wr_ctrl(3'h5, 8'h70);
        check("msb zero", s, starts);
        check("chan held", 32'h0, {29'h0, chan});
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end
    initial begin
        rstn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pins = 3'h5;
        res = 12'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_decode();
        t_read();
        t_refuse();
        summarize();
    end
endmodule
